// ### core/asm_pkg.sv
// constants, types and register map of the static memory bus sequencer
package asm_pkg;

  // ***********************************************************
  // clocking
  // ***********************************************************
  localparam real REF_OSC_MHZ       = 19.2;
  localparam real REF_OSC_PERIOD_NS = 52.083;
  localparam real BUS_CLK_FAST_MHZ  = 73.3824;
  localparam real BUS_CLK_SLOW_MHZ  = 48.9216;
  localparam real BUS_CLK_FAST_NS   = 13.63;
  localparam real PCLK_MHZ          = 100.0;

  // ***********************************************************
  // sizes
  // ***********************************************************
  localparam int CS_COUNT  = 4;
  localparam int CS_W      = 2;
  localparam int ADDR_W    = 24;
  localparam int DQ_W      = 16;
  localparam int CNT_W     = 6;
  localparam int WORDS     = 8;
  localparam int FIELD_W   = 4;

  // ***********************************************************
  // register offsets and fields
  // ***********************************************************
  localparam logic [7:0] OFS_CFG0   = 8'h00;
  localparam logic [7:0] OFS_CTRL   = 8'h10;
  localparam logic [7:0] OFS_ADDR   = 8'h14;
  localparam logic [7:0] OFS_WDATA  = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  localparam logic [7:0] OFS_RDATA0 = 8'h20;
  localparam logic [7:0] OFS_RDATAN = 8'h2C;

  localparam int RDWAIT_LSB = 0;
  localparam int WRWAIT_LSB = 4;
  localparam int DRD_LSB    = 8;
  localparam int DWR_LSB    = 12;
  localparam int HOLD_LSB   = 16;
  localparam int RECOV_LSB  = 20;
  localparam logic [31:0] CFG_RESET = 32'h0011_1100;

  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_OP_LSB    = 1;
  localparam int CTRL_CS_LSB    = 4;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_DONE_BIT  = 1;

  // extra cycles of the first page word and of the split write gap
  localparam logic [CNT_W-1:0] PAGE_FIRST_EXTRA = 6'h02;
  localparam logic [CNT_W-1:0] GAP_EXTRA        = 6'h01;
  localparam logic [2:0]       PAGE4_LAST       = 3'h3;
  localparam logic [2:0]       PAGE8_LAST       = 3'h7;

  // ***********************************************************
  // types
  // ***********************************************************
  typedef enum logic [2:0] {
    OP_READ = 3'h0, OP_WRITE = 3'h1, OP_SPLIT_RD = 3'h2,
    OP_SPLIT_WR = 3'h3, OP_PAGE4 = 3'h4, OP_PAGE8 = 3'h5
  } asm_op_type;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001, ST_RECOV = 6'b000010, ST_SETUP = 6'b000100,
    ST_STROBE = 6'b001000, ST_GAP = 6'b010000, ST_HOLD = 6'b100000
  } asm_state_type;

  typedef struct packed {
    logic [CS_W-1:0]   cs;
    asm_op_type        op;
    logic [ADDR_W-1:0] addr;
  } asm_req_type;

  typedef struct packed {
    logic [CS_COUNT-1:0] cs_n;
    logic [ADDR_W-1:0]   addr;
    logic                oe_n;
    logic                we_n;
    logic [DQ_W-1:0]     dq_out;
    logic                dq_oe;
  } asm_pins_type;

endpackage : asm_pkg

// ### core/asm_interval_counter.sv
// loadable down-counter that times the recovery, strobe, gap and hold intervals (setup is one fixed cycle)
`timescale 1ns/1ns
`default_nettype none
module asm_interval_counter #(
  parameter int W = 6
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              zero
);

  logic [W-1:0] cnt_reg;

  // one step per pclk cycle, edge to edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
    end else if (load) begin
      cnt_reg <= load_val;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - W'(1);
    end
  end

  assign zero = (cnt_reg == '0);

endmodule : asm_interval_counter
`default_nettype wire

// ### core/asm_seq.sv
// apb-controlled bus-cycle sequencer for asynchronous 16-bit memories
`timescale 1ns/1ns
`default_nettype none
module asm_seq (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  output asm_pkg::asm_pins_type          mem_pins,
  input  wire logic [asm_pkg::DQ_W-1:0]  mem_dq_in
);

  // ***********************************************************
  // functions
  // ***********************************************************
  function automatic logic [asm_pkg::CNT_W-1:0] fld(
    input logic [31:0] cfg, input int lsb);
    fld = {2'b00, cfg[lsb +: asm_pkg::FIELD_W]};
  endfunction : fld

  // counter preload for n cycles, never below one cycle
  function automatic logic [asm_pkg::CNT_W-1:0] cnt_load(
    input logic [asm_pkg::CNT_W-1:0] n);
    cnt_load = (n == '0) ? '0 : n - 6'h01;
  endfunction : cnt_load

  function automatic logic [asm_pkg::CNT_W-1:0] cyc(
    input logic [asm_pkg::CNT_W-1:0] n);
    cyc = (n == '0) ? 6'h01 : n;
  endfunction : cyc

  function automatic logic is_wr(input asm_pkg::asm_op_type op);
    is_wr = (op == asm_pkg::OP_WRITE) || (op == asm_pkg::OP_SPLIT_WR);
  endfunction : is_wr

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a[1:0] == 2'b00) &&
              ((a < asm_pkg::OFS_CTRL + 8'h00) ||
               ((a >= asm_pkg::OFS_CTRL) && (a <= asm_pkg::OFS_RDATAN)));
  endfunction : addr_ok

  // ***********************************************************
  // registers
  // ***********************************************************
  logic [31:0]               cfg_reg [asm_pkg::CS_COUNT];
  logic [asm_pkg::DQ_W-1:0]  word_reg [asm_pkg::WORDS];
  logic [asm_pkg::ADDR_W-1:0] addr_sw_reg;
  logic [31:0]               wdata_reg;
  logic                      done_reg;
  logic [31:0]               prdata_reg;
  asm_pkg::asm_req_type      req_reg;
  asm_pkg::asm_req_type      req_next;
  asm_pkg::asm_state_type    state_reg;
  asm_pkg::asm_state_type    state_next;
  logic [2:0]                idx_reg;
  logic [2:0]                idx_next;
  logic [asm_pkg::CS_W-1:0]  last_cs_reg;
  logic                      last_rd_reg;
  logic                      last_valid_reg;
  asm_pkg::asm_pins_type     pins_reg;

  logic                      apb_wr;
  logic                      busy;
  logic                      start_ok;
  asm_pkg::asm_req_type      new_req;
  logic                      need_rec;
  logic [asm_pkg::CNT_W-1:0] rec_len;
  logic [31:0]               cur_cfg;
  logic                      wr_op;
  logic                      split_op;
  logic                      page_op;
  logic [2:0]                last_idx;
  logic [asm_pkg::CNT_W-1:0] wait_f;
  logic [asm_pkg::CNT_W-1:0] strb_len;
  logic [asm_pkg::CNT_W-1:0] hold_len;
  logic                      ld;
  logic [asm_pkg::CNT_W-1:0] ld_val;
  logic                      cnt_zero;
  logic                      adv;
  logic                      cap;
  logic                      fin;
  logic                      cs_on_next;

  // ***********************************************************
  // apb slave
  // ***********************************************************
  assign apb_wr  = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok(paddr);
  assign prdata  = prdata_reg;
  assign busy    = (state_reg != asm_pkg::ST_IDLE);
  assign start_ok = apb_wr && (paddr == asm_pkg::OFS_CTRL) &&
                    pwdata[asm_pkg::CTRL_START_BIT] && !busy;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < asm_pkg::CS_COUNT; i++) begin
        cfg_reg[i] <= asm_pkg::CFG_RESET;
      end
      addr_sw_reg <= '0;
      wdata_reg   <= '0;
    end else if (apb_wr && addr_ok(paddr)) begin
      if (paddr < asm_pkg::OFS_CTRL) begin
        cfg_reg[paddr[3:2]] <= pwdata;
      end
      if (paddr == asm_pkg::OFS_ADDR) begin
        addr_sw_reg <= pwdata[asm_pkg::ADDR_W-1:0];
      end
      if (paddr == asm_pkg::OFS_WDATA) begin
        wdata_reg <= pwdata;
      end
    end
  end

  // read data captured in the setup phase, stable through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata_reg <= '0;
      // unmapped or unaligned reads return zero
      if (!addr_ok(paddr)) begin
        prdata_reg <= '0;
      end else if (paddr < asm_pkg::OFS_CTRL) begin
        prdata_reg <= cfg_reg[paddr[3:2]];
      end else if (paddr == asm_pkg::OFS_CTRL) begin
        prdata_reg <= {26'h0, req_reg.cs, req_reg.op, 1'b0};
      end else if (paddr == asm_pkg::OFS_ADDR) begin
        prdata_reg <= {8'h00, addr_sw_reg};
      end else if (paddr == asm_pkg::OFS_WDATA) begin
        prdata_reg <= wdata_reg;
      end else if (paddr == asm_pkg::OFS_STATUS) begin
        prdata_reg <= {30'h0, done_reg, busy};
      end else begin
        prdata_reg <= {word_reg[{paddr[3:2], 1'b1}],
                       word_reg[{paddr[3:2], 1'b0}]};
      end
    end
  end

  // done is sticky; a finishing transfer beats a software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_reg <= 1'b0;
    end else if (fin) begin
      done_reg <= 1'b1;
    end else if (apb_wr && (paddr == asm_pkg::OFS_STATUS) &&
                 pwdata[asm_pkg::STAT_DONE_BIT]) begin
      done_reg <= 1'b0;
    end
  end

  // ***********************************************************
  // timing decode
  // ***********************************************************
  assign new_req.cs   = pwdata[asm_pkg::CTRL_CS_LSB +: asm_pkg::CS_W];
  assign new_req.op   =
    asm_pkg::asm_op_type'(pwdata[asm_pkg::CTRL_OP_LSB +: 3]);
  assign new_req.addr = addr_sw_reg;

  assign cur_cfg  = cfg_reg[req_reg.cs];
  assign wr_op    = is_wr(req_reg.op);
  assign split_op = (req_reg.op == asm_pkg::OP_SPLIT_RD) ||
                    (req_reg.op == asm_pkg::OP_SPLIT_WR);
  assign page_op  = (req_reg.op == asm_pkg::OP_PAGE4) ||
                    (req_reg.op == asm_pkg::OP_PAGE8);
  assign last_idx = (req_reg.op == asm_pkg::OP_PAGE8) ?
                    asm_pkg::PAGE8_LAST : asm_pkg::PAGE4_LAST;
  assign wait_f   = wr_op ? fld(cur_cfg, asm_pkg::WRWAIT_LSB)
                          : fld(cur_cfg, asm_pkg::RDWAIT_LSB);
  // 1+w+d with d = field-1 collapses to w+field
  assign strb_len = wait_f + (wr_op ? fld(cur_cfg, asm_pkg::DWR_LSB)
                                    : fld(cur_cfg, asm_pkg::DRD_LSB));
  assign hold_len = fld(cur_cfg, asm_pkg::HOLD_LSB); // h, the hold field itself
  assign rec_len  = fld(cfg_reg[last_cs_reg], asm_pkg::RECOV_LSB);
  // first access after reset needs no recovery
  assign need_rec = last_valid_reg &&
                    ((last_cs_reg != new_req.cs) ||
                     (last_rd_reg && is_wr(new_req.op)));

  asm_interval_counter #(
    .W        (asm_pkg::CNT_W)
  ) u_timer (
    .pclk     (pclk),
    .presetn  (presetn),
    .load     (ld),
    .load_val (ld_val),
    .zero     (cnt_zero)
  );

  // ***********************************************************
  // sequencer
  // ***********************************************************
  always_comb begin
    state_next = state_reg;
    ld         = 1'b0;
    ld_val     = '0;
    adv        = 1'b0;
    cap        = 1'b0;
    fin        = 1'b0;
    unique case (state_reg)
      asm_pkg::ST_IDLE: begin
        if (start_ok) begin
          if (need_rec && (rec_len != '0)) begin
            state_next = asm_pkg::ST_RECOV;
            ld         = 1'b1;
            ld_val     = cnt_load(rec_len);
          end else begin
            state_next = asm_pkg::ST_SETUP;
          end
        end
      end
      asm_pkg::ST_RECOV: begin
        if (cnt_zero) begin
          state_next = asm_pkg::ST_SETUP;
        end
      end
      asm_pkg::ST_SETUP: begin
        state_next = asm_pkg::ST_STROBE;
        ld         = 1'b1;
        ld_val     = (page_op && (idx_reg == 3'h0)) ?
                     cnt_load(strb_len + asm_pkg::PAGE_FIRST_EXTRA) :
                     cnt_load(strb_len);
      end
      asm_pkg::ST_STROBE: begin
        if (cnt_zero && wr_op) begin
          ld = 1'b1;
          if (split_op && (idx_reg == 3'h0)) begin
            state_next = asm_pkg::ST_GAP;
            ld_val     = cnt_load(hold_len + asm_pkg::GAP_EXTRA);
            adv        = 1'b1;
          end else begin
            state_next = asm_pkg::ST_HOLD;
            ld_val     = cnt_load(hold_len);
          end
        end else if (cnt_zero) begin
          cap = 1'b1;
          if (split_op && (idx_reg == 3'h0)) begin
            state_next = asm_pkg::ST_SETUP;
            adv        = 1'b1;
          end else if (page_op && (idx_reg != last_idx)) begin
            ld     = 1'b1;
            ld_val = cnt_load(wait_f + 6'h01);
            adv    = 1'b1;
          end else begin
            state_next = asm_pkg::ST_IDLE;
            fin        = 1'b1;
          end
        end
      end
      asm_pkg::ST_GAP: begin
        if (cnt_zero) begin
          state_next = asm_pkg::ST_STROBE;
          ld         = 1'b1;
          ld_val     = cnt_load(strb_len);
        end
      end
      asm_pkg::ST_HOLD: begin
        if (cnt_zero) begin
          state_next = asm_pkg::ST_IDLE;
          fin        = 1'b1;
        end
      end
    endcase
  end

  always_comb begin
    req_next = start_ok ? new_req : req_reg;
    idx_next = start_ok ? 3'h0 : idx_reg;
    if (adv) begin
      req_next.addr = req_reg.addr + asm_pkg::ADDR_W'(1);
      idx_next      = idx_reg + 3'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= asm_pkg::ST_IDLE;
      req_reg   <= '0;
      idx_reg   <= '0;
    end else begin
      state_reg <= state_next;
      req_reg   <= req_next;
      idx_reg   <= idx_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_cs_reg    <= '0;
      last_rd_reg    <= 1'b0;
      last_valid_reg <= 1'b0;
    end else if (fin) begin
      last_cs_reg    <= req_reg.cs;
      last_rd_reg    <= !wr_op;
      last_valid_reg <= 1'b1;
    end
  end

  // data sampled on the edge that ends each word's strobe interval; oe_n stays low between page words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < asm_pkg::WORDS; i++) begin
        word_reg[i] <= '0;
      end
    end else if (cap) begin
      word_reg[idx_reg] <= mem_dq_in;
    end
  end

  // ***********************************************************
  // pins, registered from the next state
  // ***********************************************************
  assign cs_on_next = (state_next == asm_pkg::ST_SETUP) ||
                      (state_next == asm_pkg::ST_STROBE) ||
                      (state_next == asm_pkg::ST_GAP) ||
                      (state_next == asm_pkg::ST_HOLD);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_reg.cs_n   <= '1;
      pins_reg.addr   <= '0;
      pins_reg.oe_n   <= 1'b1;
      pins_reg.we_n   <= 1'b1;
      pins_reg.dq_out <= '0;
      pins_reg.dq_oe  <= 1'b0;
    end else begin
      pins_reg.cs_n <= cs_on_next ?
        ~(asm_pkg::CS_COUNT'(1) << req_next.cs) : '1;
      pins_reg.addr <= req_next.addr;
      pins_reg.oe_n <= !((state_next == asm_pkg::ST_STROBE) &&
                         !is_wr(req_next.op));
      pins_reg.we_n <= !((state_next == asm_pkg::ST_STROBE) &&
                         is_wr(req_next.op));
      pins_reg.dq_out <= idx_next[0] ? wdata_reg[31:16]
                                     : wdata_reg[15:0];
      // driven from the strobe start, released after hold
      pins_reg.dq_oe <= is_wr(req_next.op) && cs_on_next &&
                        (state_next != asm_pkg::ST_SETUP);
    end
  end

  assign mem_pins = pins_reg;

  // ***********************************************************
  // checks
  // ***********************************************************
  logic                      cs_on;
  logic [asm_pkg::CNT_W-1:0] cs_len;
  logic [asm_pkg::CNT_W-1:0] we_len;
  assign cs_on = ~&pins_reg.cs_n;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_len <= '0;
      we_len <= '0;
    end else begin
      cs_len <= cs_on ? cs_len + 6'h01 : '0;
      we_len <= !pins_reg.we_n ? we_len + 6'h01 : '0;
    end
  end

  a_strobe_excl: assert property (@(posedge pclk) disable iff (!presetn)
    !(!pins_reg.oe_n && !pins_reg.we_n))
    else $error("read and write strobes both active");
  a_bus_release: assert property (@(posedge pclk) disable iff (!presetn)
    pins_reg.dq_oe |-> wr_op && cs_on)
    else $error("data bus driven outside a write");
  a_we_after_cs: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(cs_on) && wr_op |-> pins_reg.we_n ##1 !pins_reg.we_n)
    else $error("write strobe not one cycle after select");
  a_oe_after_cs: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(cs_on) && !wr_op |-> pins_reg.oe_n ##1 !pins_reg.oe_n)
    else $error("read strobe not one cycle after select");
  a_rd_end_join: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(cs_on) && !wr_op |-> $rose(pins_reg.oe_n))
    else $error("read strobe and select did not end together");
  a_wr_strobe_len: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(pins_reg.we_n) |-> we_len == cyc(strb_len))
    else $error("write strobe length wrong");
  a_wr_data_setup: assert property (@(posedge pclk) disable iff (!presetn)
    !pins_reg.we_n |-> pins_reg.dq_oe)
    else $error("write strobe without data driven");
  a_wr_cs_len: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(cs_on) && (req_reg.op == asm_pkg::OP_WRITE) |->
      cs_len == 6'h01 + cyc(strb_len) + cyc(hold_len))
    else $error("write select length wrong");
  a_rd_cs_len: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(cs_on) && (req_reg.op == asm_pkg::OP_READ) |->
      cs_len == 6'h01 + cyc(strb_len))
    else $error("read select length wrong");
  a_page_held: assert property (@(posedge pclk) disable iff (!presetn)
    page_op && (state_reg == asm_pkg::ST_STROBE) |->
      cs_on && !pins_reg.oe_n)
    else $error("page read dropped select or strobe");

endmodule : asm_seq
`default_nettype wire

// ### test/asm_mem_model.sv
// behavioural 16-bit asynchronous memory at the far side of the pins
`timescale 1ns/1ns
`default_nettype none
module asm_mem_model (
  input  wire logic                  pclk,
  input  wire asm_pkg::asm_pins_type pins,
  output logic [15:0]                dq
);
  logic [15:0] mem [0:255];
  logic [15:0] last;
  logic        sel;
  initial for (int i = 0; i < 256; i++) mem[i] = 16'(i) ^ 16'h5A5A;
  initial last = 16'h0000;
  assign sel = pins.cs_n != 4'hF;
  // takes the write data while the write strobe is low and dq_oe drives the bus
  always @(posedge pclk) begin
    if (sel && !pins.we_n && pins.dq_oe) begin
      mem[pins.addr[7:0]] <= pins.dq_out;
    end
    last <= dq;
  end
  // no pull on the bus, so a released bus flips every cycle
  assign dq = (sel && !pins.oe_n) ? mem[pins.addr[7:0]] : ~last;
endmodule : asm_mem_model
`default_nettype wire

// ### test/asm_seq_tb.sv
// self-checking bench of the static memory bus sequencer
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end
module asm_seq_tb;
  logic                  pclk = 0, presetn = 0, psel = 0, penable = 0;
  logic                  pwrite = 0, pready, pslverr, first = 1, last_rd;
  logic [7:0]            paddr = 8'h00;
  logic [31:0]           pwdata = 32'h0, prdata;
  asm_pkg::asm_pins_type pins;
  logic [15:0]           dq_in;
  logic [64:0]           q[$];
  logic [64:0]           e;
  logic [31:0]           cfg[4];
  logic [15:0]           shad[0:255];
  logic [23:0]           a;
  logic [1:0]            last_cs, cs;
  logic [2:0]            ops[6] = '{3'h1, 3'h0, 3'h3, 3'h2, 3'h4, 3'h5};
  int                    err_count = 0, checked = 0;
  always #5 pclk = ~pclk;
  asm_seq dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_pins(pins),
    .mem_dq_in(dq_in));
  asm_mem_model mem (.pclk(pclk), .pins(pins), .dq(dq_in));
  task end_sim;
    if (err_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  // read results are judged here, off the driver's queue
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && q.size() > 0) begin
      e = q.pop_front();
      `CHK("prdata", prdata & e[64:33], e[31:0])
      `CHK("pslverr", pslverr, e[32])
    end
  end
  task apb(input logic wr, input logic [7:0] ad, input logic [31:0] d,
           input logic [31:0] m);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= ad; pwdata <= d;
    if (!wr) q.push_back({m, ad > 8'h2C || ad[1:0] != 2'h0, d & m});
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin n++; @(posedge pclk); end
    if (n == 20) begin err_count++; end_sim(); end
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task run_op(input logic [2:0] op, input logic [31:0] wd);
    int pre, csc, stc, n, s, h, w, st, csx, wn, rec, bad;
    logic rd;
    logic [31:0] c;
    c = cfg[cs];
    rd = op != 3'h1 && op != 3'h3;
    w = rd ? c[3:0] : c[7:4];
    s = w + (rd ? c[11:8] : c[15:12]);
    h = c[19:16];
    wn = op == 3'h5 ? 8 : op == 3'h4 ? 4 : op == 3'h2 ? 2 : 1;
    st = op[2] ? s + 2 + (wn - 1) * (w + 1) : (op[1] ? 2 * s : s);
    csx = 1 + st + (op == 3'h2) + (op == 3'h1 ? h : 0) +
          (op == 3'h3 ? 1 + 2 * h : 0);
    rec = (first || (cs == last_cs && !(last_rd && !rd))) ? 0
          : cfg[last_cs][23:20];
    apb(1'b1, 8'h14, {8'h00, a}, 32'h0);
    apb(1'b1, 8'h18, wd, 32'h0);
    apb(1'b1, 8'h10, {26'h0, cs, op, 1'b1}, 32'h0);
    pre = 0; csc = 0; stc = 0; n = 0; bad = 0;
    while (n < 400 && !(csc > 0 && pins.cs_n == 4'hF)) begin
      @(posedge pclk);
      n++;
      if (pins.cs_n == 4'hF) pre += (csc == 0);
      else csc++;
      if (!pins.we_n || !pins.oe_n) stc++;
      if (csc == 1 && (!pins.we_n || !pins.oe_n)) bad++;
      if (!pins.we_n && !pins.oe_n || rd && pins.dq_oe) bad++;
      if (!pins.we_n && pins.dq_oe !== 1'b1) bad++;
      if (op < 3'h2 && pins.addr !== a) bad++;
      if (pins.cs_n != 4'hF && pins.cs_n !== ~(4'h1 << cs)) bad++;
    end
    if (n == 400) begin err_count++; end_sim(); end
    `CHK("recovery", pre, rec)
    `CHK("select", csc, csx)
    `CHK("strobe", stc, st)
    `CHK("pins", bad, 0)
    `CHK("release", pins.dq_oe, 1'b0)
    apb(1'b0, 8'h1C, 32'h2, 32'h3);
    apb(1'b1, 8'h1C, 32'h2, 32'h0);
    // done must be gone after the write-one clear
    apb(1'b0, 8'h1C, 32'h0, 32'h3);
    apb(1'b0, 8'h10, {26'h0, cs, op, 1'b0}, 32'hFFFFFFFF);
    apb(1'b0, 8'h18, wd, 32'hFFFFFFFF);
    last_cs = cs; last_rd = rd; first = 0;
    if (op == 3'h1 || op == 3'h3) shad[a] = wd[15:0];
    if (op == 3'h3) shad[a + 1] = wd[31:16];
    // single read leaves the upper half stale, so it is masked off
    for (int k = 0; rd && k < (wn + 1) / 2; k++)
      apb(1'b0, 8'(8'h20 + 4 * k), {shad[a + 2 * k + 1], shad[a + 2 * k]},
          wn == 1 ? 32'h0000FFFF : 32'hFFFFFFFF);
  endtask : run_op
  initial begin
    void'($urandom(59479));
    for (int i = 0; i < 256; i++) shad[i] = 16'(i) ^ 16'h5A5A;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      cfg[i] = asm_pkg::CFG_RESET;
      apb(1'b0, 8'(4 * i), asm_pkg::CFG_RESET, 32'hFFFFFFFF);
    end
    apb(1'b1, 8'h40, 32'h1234, 32'h0);
    apb(1'b0, 8'h40, 32'h0, 32'hFFFFFFFF);
    apb(1'b0, 8'h02, 32'h0, 32'hFFFFFFFF);
    a = 24'(16 + $urandom % 200);
    for (int i = 0; i < 18; i++) begin
      cs = 2'($urandom % 4);
      cfg[cs] = {8'h00, 4'(1 + $urandom % 3), 4'(1 + $urandom % 3),
        4'(1 + $urandom % 3), 4'(1 + $urandom % 3), 4'($urandom % 3),
        4'($urandom % 3)};
      apb(1'b1, 8'(4 * cs), cfg[cs], 32'h0);
      apb(1'b0, 8'(4 * cs), cfg[cs], 32'hFFFFFFFF);
      run_op(ops[i % 6], $urandom);
    end
    end_sim();
  end
endmodule : asm_seq_tb
`default_nettype wire
